// ---- shared/amp_diag_pkg.sv ----
// Package: constants, register map and carriers for the amplifier
// diagnostic sequencer. Assumes a single 40 MHz clock domain.
package amp_diag_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 25;
    localparam int TICK_TIME_NS    = 1_000_000;
    localparam int MS_CYCLES       = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECHECK_TIME_MS = 1;
    localparam int ACQ_TIME_MS     = 100;
    localparam int DIAG_TIME_MS    = 100;
    localparam int AC_MIN_PULSES   = 3;
    localparam int NCH             = 4;

    localparam logic [6:0] RECHECK_LAST = 7'(RECHECK_TIME_MS - 1);
    localparam logic [6:0] ACQ_LAST     = 7'(ACQ_TIME_MS - 1);
    localparam logic [6:0] DIAG_LAST    = 7'(DIAG_TIME_MS - 1);
    localparam logic [1:0] AC_ENOUGH    = 2'(AC_MIN_PULSES);

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] OFS_CTRL1  = 4'h0;
    localparam logic [3:0] OFS_CTRL2  = 4'h4;
    localparam logic [3:0] OFS_RESULT = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int C1_UNMUTE_REAR  = 1;
    localparam int C1_UNMUTE_FRONT = 2;
    localparam int C1_DIAG_EN      = 3;
    localparam int C1_STANDBY_MUTE_PIN_OUT     = 4;
    localparam int C1_OFFSET_EN    = 5;
    localparam int C2_AC_EN        = 2;
    localparam int C2_AC_LOW       = 7;

    // Turn-on code replaced once a permanent short is seen
    localparam logic [1:0] CODE_PERM_SHORT = 2'b11;

    // ------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] overload;
        logic [3:0] offset_high;
        logic [3:0] ac_pulse;
        logic [7:0] turnon_code;
    } sense_s;

    typedef struct packed {
        logic [7:0] turnon;
        logic [3:0] ac_open;
        logic [3:0] offset;
        logic [3:0] short;
    } result_s;

    localparam int RES_W = $bits(result_s);

    typedef enum logic [1:0] {
        CH_ACTIVE  = 2'b00,
        CH_RECHECK = 2'b01,
        CH_DIAG    = 2'b10,
        CH_RESTART = 2'b11
    } chan_state_e;

    typedef enum logic [1:0] {
        ON_STANDBY_MUTE_PIN   = 2'b00,
        ON_PULSE  = 2'b01,
        ON_BIASED = 2'b10
    } turnon_state_e;

endpackage : amp_diag_pkg

// ---- src/chan_guard.sv ----
// Per-channel permanent short-circuit guard: restart and diagnostic modes.
// Assumes a synchronised overload level and a one-cycle millisecond tick.
`timescale 1ns/1ps
module chan_guard (
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    input  wire logic ms_tick_i,
    input  wire logic overload_i,
    input  wire logic diag_en_i,
    input  wire logic rearm_i,
    output logic      chan_on_o,
    output logic      fault_o,
    output logic      protect_o
);
    import amp_diag_pkg::*;

    chan_state_e state_q, state_d;
    logic [6:0]  ms_q;
    logic        done_q;
    logic        diag_end;

    always_comb begin
        state_d  = state_q;
        diag_end = 1'b0;
        case (state_q)
            CH_ACTIVE: begin
                if (overload_i) begin
                    // Self-activation; a finished cycle waits for a read
                    state_d = (diag_en_i && !done_q) ? CH_RECHECK : CH_RESTART;
                end
            end
            CH_RECHECK: begin
                if (ms_tick_i && ms_q == RECHECK_LAST) begin
                    state_d = overload_i ? CH_DIAG : CH_ACTIVE;
                end
            end
            CH_DIAG: begin
                if (ms_tick_i && ms_q == DIAG_LAST) begin
                    state_d  = CH_RESTART;
                    diag_end = 1'b1;
                end
            end
            CH_RESTART: begin
                if (ms_tick_i && !overload_i) begin
                    state_d = CH_ACTIVE;
                end
            end
            default: state_d = CH_ACTIVE;
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= CH_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ms_q <= 7'h00;
        end else if (state_d != state_q) begin
            ms_q <= 7'h00;
        end else if (ms_tick_i) begin
            ms_q <= ms_q + 7'h01;
        end
    end

    // Completion beats a read landing in the same cycle
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_q <= 1'b0;
        end else if (diag_end) begin
            done_q <= 1'b1;
        end else if (rearm_i) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chan_on_o <= 1'b1;
            fault_o   <= 1'b0;
            protect_o <= 1'b0;
        end else begin
            chan_on_o <= (state_d == CH_ACTIVE);
            fault_o   <= diag_end;
            protect_o <= (state_d != CH_ACTIVE);
        end
    end

    a_recheck_off: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        state_q == CH_RECHECK |-> !chan_on_o)
        else $error("channel on during recheck");
    a_check_to_diag: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_q == CH_RECHECK && ms_tick_i && overload_i) |=> state_q == CH_DIAG)
        else $error("overload at recheck did not start diagnostic");
    a_diag_to_restart: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_q == CH_DIAG ##1 state_q != CH_DIAG) |-> state_q == CH_RESTART && fault_o)
        else $error("diagnostic end without restart and record");
    a_wait_for_read: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_q == CH_ACTIVE && done_q) |=> state_q != CH_RECHECK)
        else $error("new cycle started before a read");

endmodule : chan_guard

// ---- src/amp_diag_seq.sv ----
// Diagnostic sequencer of a four-channel amplifier: turn-on test pulse,
// permanent short guard, offset window and AC tweeter pulse count.
// Assumes sense inputs come from analog comparators, asynchronous to clock_i.
//
// Contract
// - Turn-on result kept until a new pulse, which needs a prior read.
// - Standby-out with diag enable runs pulse first, stage off.
// - After bias, permanent diagnostic runs; turn-on result kept until short.
// - Output status captured at end of 100 ms pulse plateau.
// - Restart mode shuts faulty channel, checks each ms, restarts.
// - Diagnostic mode by host enable, self-activated by overload.
// - Recheck after 1 ms; no overload returns channel active.
// - Overload still present at recheck starts 100 ms diagnostic.
// - After diagnostic, channel to restart mode, fault stored.
// - Next permanent cycle only after completed cycle and a read.
// - Offset beyond two volts either polarity flags the channel.
// - Offset window opens at last read or enable, closes at read.
// - Offset reported only if present over whole window.
// - Overload protection suspends offset and AC tests.
// - AC test runs only while control byte two bit two set.
// - Control byte two bit seven selects low AC thresholds.
// - Fewer than three current pulses reports open tweeter.
// - Read returns previous results and re-arms; change on second read.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
module amp_diag_seq #(
    parameter int MS_CYCLES = amp_diag_pkg::MS_CYCLES
) (
    input  wire logic                          clock_i,
    input  wire logic                          reset_n_i,
    input  wire logic [amp_diag_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [amp_diag_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic      [amp_diag_pkg::DATA_W-1:0] rdata_o,
    input  wire amp_diag_pkg::sense_s          sense_i,
    output logic                               stage_off_o,
    output logic                               test_pulse_o,
    output logic      [amp_diag_pkg::NCH-1:0]  chan_on_o,
    output logic      [1:0]                    unmute_o,
    output logic                               ac_thresh_low_o
);
    import amp_diag_pkg::*;

    localparam int TB_W = $clog2(MS_CYCLES + 1);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    sense_s s1_q;
    sense_s s2_q;
    logic [NCH-1:0] pulse_prev_q;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_q         <= '0;
            s2_q         <= '0;
            pulse_prev_q <= '0;
        end else begin
            s1_q         <= sense_i;
            s2_q         <= s1_q;
            pulse_prev_q <= s2_q.ac_pulse;
        end
    end

    // ------------------------------------------------------------
    // Millisecond timebase
    // ------------------------------------------------------------
    logic [TB_W-1:0] tb_q;
    logic            ms_tick_q;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tb_q      <= '0;
            ms_tick_q <= 1'b0;
        end else if (tb_q == TB_W'(MS_CYCLES - 1)) begin
            tb_q      <= '0;
            ms_tick_q <= 1'b1;
        end else begin
            tb_q      <= tb_q + TB_W'(1);
            ms_tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control bytes
    // ------------------------------------------------------------
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic       wr1;
    logic       wr2;
    logic       rd_res;
    logic       ofs_open;
    logic       ac_open_evt;

    assign wr1    = wr_i && addr_i == OFS_CTRL1;
    assign wr2    = wr_i && addr_i == OFS_CTRL2;
    assign rd_res = rd_i && addr_i == OFS_RESULT;
    assign ofs_open = rd_res || (wr1 && wdata_i[C1_OFFSET_EN] && !ctrl1_q[C1_OFFSET_EN]);
    assign ac_open_evt = rd_res || (wr2 && wdata_i[C2_AC_EN] && !ctrl2_q[C2_AC_EN]);

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl1_q <= CTRL_RESET;
        end else if (wr1) begin
            ctrl1_q <= wdata_i[7:0];
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl2_q <= CTRL_RESET;
        end else if (wr2) begin
            ctrl2_q <= wdata_i[7:0];
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            unmute_o        <= 2'b00;
            ac_thresh_low_o <= 1'b0;
        end else begin
            unmute_o        <= {ctrl1_q[C1_UNMUTE_FRONT], ctrl1_q[C1_UNMUTE_REAR]};
            ac_thresh_low_o <= ctrl2_q[C2_AC_LOW];
        end
    end

    // ------------------------------------------------------------
    // Turn-on test sequence
    // ------------------------------------------------------------
    turnon_state_e state_q, state_d;
    logic [6:0]    acq_q;
    logic          armed_q;
    logic          capture;

    always_comb begin
        state_d = state_q;
        capture = 1'b0;
        case (state_q)
            ON_STANDBY_MUTE_PIN: begin
                if (wr1 && wdata_i[C1_STANDBY_MUTE_PIN_OUT]) begin
                    // With diag enable and armed_q, pulse goes first and bias follows after the plateau; otherwise bias at once
                    state_d = (wdata_i[C1_DIAG_EN] && armed_q) ? ON_PULSE : ON_BIASED;
                end
            end
            ON_PULSE: begin
                if (ms_tick_q && acq_q == ACQ_LAST) begin
                    state_d = ON_BIASED;
                    capture = 1'b1;
                end
            end
            ON_BIASED: begin
                if (wr1 && !wdata_i[C1_STANDBY_MUTE_PIN_OUT]) begin
                    state_d = ON_STANDBY_MUTE_PIN;
                end
            end
            default: state_d = ON_STANDBY_MUTE_PIN;
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ON_STANDBY_MUTE_PIN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acq_q <= 7'h00;
        end else if (state_q != ON_PULSE) begin
            acq_q <= 7'h00;
        end else if (ms_tick_q) begin
            acq_q <= acq_q + 7'h01;
        end
    end

    // Only a read or a reset allows the next pulse request
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            armed_q <= 1'b1;
        end else if (rd_res) begin
            armed_q <= 1'b1;
        end else if (state_d == ON_PULSE && state_q == ON_STANDBY_MUTE_PIN) begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage_off_o  <= 1'b1;
            test_pulse_o <= 1'b0;
        end else begin
            stage_off_o  <= (state_d != ON_BIASED);
            test_pulse_o <= (state_d == ON_PULSE);
        end
    end

    // ------------------------------------------------------------
    // Per-channel permanent, offset and AC diagnostics
    // ------------------------------------------------------------
    logic           perm_en;
    logic [NCH-1:0] fault;
    logic [NCH-1:0] protect;
    logic [NCH-1:0] short_q;
    logic [NCH-1:0] ofs_ok_q;
    logic [NCH-1:0] ofs_live;
    logic [NCH-1:0] ac_abort_q;
    logic [NCH-1:0] ac_live;
    logic [7:0]     turnon_q;
    logic [1:0]     acn_q [NCH];

    assign perm_en = ctrl1_q[C1_DIAG_EN] && state_q == ON_BIASED;

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            chan_guard u_guard (
                .clock_i   (clock_i),
                .reset_n_i (reset_n_i),
                .ms_tick_i (ms_tick_q),
                .overload_i(s2_q.overload[ch]),
                .diag_en_i (perm_en),
                .rearm_i   (rd_res),
                .chan_on_o (chan_on_o[ch]),
                .fault_o   (fault[ch]),
                .protect_o (protect[ch])
            );

            // Each channel keeps its own record
            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    short_q[ch] <= 1'b0;
                end else if (fault[ch]) begin
                    short_q[ch] <= 1'b1;
                end else if (rd_res) begin
                    short_q[ch] <= 1'b0;
                end
            end

            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    turnon_q[2*ch +: 2] <= 2'b00;
                end else if (capture) begin
                    turnon_q[2*ch +: 2] <= s2_q.turnon_code[2*ch +: 2];
                end else if (fault[ch]) begin
                    turnon_q[2*ch +: 2] <= CODE_PERM_SHORT;
                end
            end

            // Window survives only while the offset stays high
            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    ofs_ok_q[ch] <= 1'b0;
                end else if (ofs_open) begin
                    ofs_ok_q[ch] <= 1'b1;
                end else if (!s2_q.offset_high[ch] || protect[ch]) begin
                    ofs_ok_q[ch] <= 1'b0;
                end
            end
            assign ofs_live[ch] = ctrl1_q[C1_OFFSET_EN] && ofs_ok_q[ch]
                                  && s2_q.offset_high[ch];

            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    acn_q[ch]      <= 2'b00;
                    ac_abort_q[ch] <= 1'b0;
                end else if (ac_open_evt) begin
                    acn_q[ch]      <= 2'b00;
                    ac_abort_q[ch] <= 1'b0;
                end else if (protect[ch]) begin
                    ac_abort_q[ch] <= 1'b1;
                end else if (ctrl2_q[C2_AC_EN] && s2_q.ac_pulse[ch] && !pulse_prev_q[ch]
                             && acn_q[ch] != AC_ENOUGH) begin
                    acn_q[ch] <= acn_q[ch] + 2'b01;
                end
            end
            assign ac_live[ch] = ctrl2_q[C2_AC_EN] && !ac_abort_q[ch]
                                 && acn_q[ch] != AC_ENOUGH;
        end
    endgenerate

    // ------------------------------------------------------------
    // Result snapshot and read path
    // ------------------------------------------------------------
    result_s live;
    result_s shadow_q;

    always_comb begin
        live.turnon  = turnon_q;
        live.ac_open = ac_live;
        live.offset  = ofs_live;
        live.short   = short_q;
    end

    // Read hands out the previous snapshot and takes a fresh one
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shadow_q <= '0;
        end else if (rd_res) begin
            shadow_q <= live;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                OFS_CTRL1:  rdata_o <= {24'h00_0000, ctrl1_q};
                OFS_CTRL2:  rdata_o <= {24'h00_0000, ctrl2_q};
                OFS_RESULT: rdata_o <= {{(DATA_W - RES_W){1'b0}}, shadow_q};
                OFS_STATUS: rdata_o <= {25'h000_0000, armed_q, state_q, chan_on_o};
                default:    rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_pulse_stage_off: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_q == ON_STANDBY_MUTE_PIN && wr1 && wdata_i[C1_STANDBY_MUTE_PIN_OUT] && wdata_i[C1_DIAG_EN] && armed_q)
        |=> test_pulse_o && stage_off_o)
        else $error("stage on during test pulse");
    a_pulse_needs_arm: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $rose(test_pulse_o) |-> $past(armed_q) && !armed_q)
        else $error("pulse without prior read");
    a_plateau_length: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_q == ON_PULSE && state_d == ON_BIASED) |-> acq_q == ACQ_LAST && ms_tick_q)
        else $error("capture off the plateau end");
    a_read_previous: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rd_res |=> rdata_o[RES_W-1:0] == $past(shadow_q) && shadow_q == $past(live))
        else $error("read did not return previous snapshot");
    a_offset_persist: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rd_res |=> (shadow_q.offset & ~$past(ofs_ok_q)) == '0)
        else $error("offset flagged without whole window");
    a_ac_gate: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !ctrl2_q[C2_AC_EN] |-> ac_live == '0)
        else $error("AC result while test disabled");

endmodule : amp_diag_seq

// ---- bench/host_model.sv ----
// Host side of the register bus: timed write and read cycles.
// Assumes the sequencer never stalls and answers a read one cycle later.
`timescale 1ns/1ps
module host_model (
    input  wire logic                          clock_i,
    input  wire logic [amp_diag_pkg::DATA_W-1:0] rdata_i,
    output logic      [amp_diag_pkg::ADDR_W-1:0] addr_o,
    output logic      [amp_diag_pkg::DATA_W-1:0] wdata_o,
    output logic                               wr_o,
    output logic                               rd_o
);
    import amp_diag_pkg::*;
    initial begin
        addr_o = '0;
        wdata_o = '0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock_i);
        addr_o <= a;
        wdata_o <= v;
        wr_o <= 1'b1;
        @(posedge clock_i);
        wr_o <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clock_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clock_i);
        rd_o <= 1'b0;
        // Data stand in the cycle after the strobe; taken at its closing edge
        @(posedge clock_i);
        v = rdata_i;
    endtask : rd_reg
    // Unmute goes out in the same write that leaves standby, before any ramp
    task automatic power_up();
        wr_reg(OFS_CTRL1, 32'h0000_001E);
    endtask : power_up
endmodule : host_model

// ---- bench/amp_output_diagnostics_sequencer_test.sv ----
// Self-checking bench of the diagnostic sequencer, 1 ms shortened to 20 clocks.
// Assumes host_model as bus master; sense levels driven here.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module amp_output_diagnostics_sequencer_test;
    import amp_diag_pkg::*;
    localparam int MS = 20;
    typedef struct {logic [3:0] wa; logic [31:0] wd; logic [3:0] ra; logic [31:0] re;} row_s;
    row_s rows [5] = '{'{4'h0, 32'h6, 4'h0, 32'h6}, '{4'h4, 32'h84, 4'h4, 32'h84},
        '{4'h1, 32'hFF, 4'h1, 32'h0}, '{4'hC, 32'hFF, 4'hC, 32'h4F},
        '{4'h4, 32'h80, 4'h4, 32'h80}};
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, d;
    logic wr, rd, stage_off, test_pulse, ac_low, bad;
    logic [3:0] chan_on;
    logic [1:0] unmute;
    sense_s sense = '0;
    int error_cnt = 0;
    int check_count = 0;
    int n;
    always #12.5 clock_i = ~clock_i;
    host_model u_host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    amp_diag_seq #(.MS_CYCLES(MS)) u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .sense_i(sense), .stage_off_o(stage_off), .test_pulse_o(test_pulse),
        .chan_on_o(chan_on), .unmute_o(unmute), .ac_thresh_low_o(ac_low));
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge clock_i);
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge clock_i);
        `CHK({stage_off, test_pulse, chan_on, unmute, ac_low}, 9'h178)
        reset_n_i <= 1'b1;
        foreach (rows[i]) begin
            u_host.wr_reg(rows[i].wa, rows[i].wd);
            u_host.rd_reg(rows[i].ra, d);
            `CHK(d, rows[i].re)
        end
        `CHK({unmute, ac_low}, 3'b111)
        // ----------------------------------------
        // Turn-on pulse
        // ----------------------------------------
        sense.turnon_code <= 8'hE4;
        u_host.power_up();
        #1 `CHK({test_pulse, stage_off}, 2'b11)
        n = 0;
        bad = 1'b0;
        while (test_pulse === 1'b1 && n < 3000) begin
            if (stage_off !== 1'b1) bad = 1'b1;
            @(posedge clock_i);
            #1 n++;
        end
        `CHK({bad, n >= 99 * MS && n <= 100 * MS + 2}, 2'b01)
        repeat (2) @(posedge clock_i);
        `CHK(stage_off, 1'b0)
        u_host.rd_reg(OFS_RESULT, d);
        `CHK(d, 32'h0)
        u_host.rd_reg(OFS_RESULT, d);
        `CHK(d, 32'h000E_4000)
        // ----------------------------------------
        // Short guard: transient, then permanent
        // ----------------------------------------
        sense.overload <= 4'b0100;
        // One-cycle glitch, gone before any millisecond recheck
        @(posedge clock_i);
        sense.overload <= 4'b0000;
        repeat (3 * MS) @(posedge clock_i);
        `CHK(chan_on, 4'hF)
        sense.overload <= 4'b0010;
        repeat (5) @(posedge clock_i);
        `CHK(chan_on, 4'hD)
        repeat (510 * MS) @(posedge clock_i);
        `CHK(chan_on, 4'hD)
        sense.overload <= 4'b0000;
        repeat (3 * MS) @(posedge clock_i);
        `CHK(chan_on, 4'hF)
        u_host.rd_reg(OFS_RESULT, d);
        u_host.rd_reg(OFS_RESULT, d);
        `CHK({d[19:12], d[3:0]}, 12'hEC2)
        // ----------------------------------------
        // Offset window and AC pulse count
        // ----------------------------------------
        sense.offset_high <= 4'b1001;
        u_host.wr_reg(OFS_CTRL1, 32'h0000_003E);
        u_host.wr_reg(OFS_CTRL2, 32'h0000_0084);
        for (int k = 0; k < 3; k++) begin
            sense.ac_pulse <= (k < 2) ? 4'b0011 : 4'b0001;
            repeat (4) @(posedge clock_i);
            sense.ac_pulse <= 4'b0000;
            sense.offset_high <= 4'b0001;
            repeat (4) @(posedge clock_i);
        end
        u_host.rd_reg(OFS_RESULT, d);
        u_host.rd_reg(OFS_RESULT, d);
        `CHK(d[11:4], 8'hE1)
        // ----------------------------------------
        // Standby round trip without pulse, restart mode
        // ----------------------------------------
        u_host.wr_reg(OFS_CTRL1, 32'h0000_0006);
        u_host.wr_reg(OFS_CTRL1, 32'h0000_0016);
        u_host.rd_reg(OFS_STATUS, d);
        `CHK({d, test_pulse, stage_off}, 34'h0_0000_01BC)
        sense.overload <= 4'b1000;
        repeat (5) @(posedge clock_i);
        `CHK(chan_on, 4'h7)
        sense.overload <= 4'b0000;
        repeat (3 * MS) @(posedge clock_i);
        `CHK(chan_on, 4'hF)
        // ----------------------------------------
        // Reset in mid-run
        // ----------------------------------------
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        `CHK({stage_off, test_pulse, chan_on, unmute, ac_low, rdata}, 41'h178_0000_0000)
        reset_n_i <= 1'b1;
        u_host.rd_reg(OFS_CTRL2, d);
        `CHK(d, 32'h0)
        conclude();
    end
endmodule : amp_output_diagnostics_sequencer_test
